// ==== core/timer_pwm_channels.v ====
// Six-channel 16-bit PWM timer with shared modulo counter and linked pairs.
// Assumes a classic Wishbone master on I_CLOCK and an async external count pin.
//
// Contract
// (R1) Overflow toggles output when toggle enabled
// (R2) Pulse lasts from overflow to compare
// (R3) Period and width set by 16-bit values
// (R4) Compare flag marks end of pulse
// (R5) Overflow flag marks end of period
// (R6) Unsynced unbuffered writes may miss compares
// (R7) Software avoids toggle action for PWM
// (R8) Even buffer bit links next odd channel
// (R9) Last written pair member governs each period
// (R10) Even control rules pair; odd pin freed
// (R11) Software writes only inactive pair member
// (R12) Software follows stop-period-width-mode-start order
// (R13) Mode bits: unbuffered 0:1, buffered wins
// (R14) Action 1:0 clears, 1:1 sets on compare
// (R15) No overflow toggle gives zero duty
// (R16) Full duty bit forces pulse level
// (R17) Overflow flag on rollover, enable requests
// (R18) Channel flag on compare, enable requests
// (R19) Wait mode: runs, bus blocked, wakes
// (R20) Stop mode halts, keeps all state
// (R21) Debug break halts counter
// (R22) Break blocks flag clears unless enabled
// (R23) Flag clear: read set, write zero
// (R24) Divider select 1..64 or external clock
// (R25) Reset leaves counter halted
// (R26) Counter reset bit clears counter, reads 0
// (R27) Count per tick, wrap after period
`timescale 1ns/1ps
`include "timer_pwm_map.vh"

module timer_pwm_channels #(
  parameter NUM_CH = 6
) (
  // Clock and reset
  input  wire                I_CLOCK,
  input  wire                I_RST_N,
  // Wishbone slave
  input  wire                I_WB_CYC,
  input  wire                I_WB_STB,
  input  wire                I_WB_WE,
  input  wire [7:0]          I_WB_ADR,
  input  wire [3:0]          I_WB_SEL,
  input  wire [31:0]         I_WB_DAT,
  output wire [31:0]         O_WB_DAT,
  output wire                O_WB_ACK,
  // System state
  input  wire                I_WAIT_MODE,
  input  wire                I_STOP_MODE,
  input  wire                I_BREAK,
  input  wire                I_BREAK_CLEAR_EN,
  input  wire                I_EXT_CLK,
  // Requests
  output wire                O_OVF_IRQ,
  output wire [NUM_CH-1:0]   O_CH_IRQ,
  output wire                O_WAKE,
  // Channel pins
  output wire [NUM_CH-1:0]   O_CH_OUT,
  output wire [NUM_CH-1:0]   O_CH_OE
);

  // ============================================================
  // Helpers
  function [7:0] ch_adr;
    input integer n;
    begin
      ch_adr = `TPWM_ADR_CH_BASE + {n[4:0], 3'b000};
    end
  endfunction

  function presc_tick;
    input [2:0] code;
    input [6:0] cnt;
    input       ext_rise;
    reg   [6:0] mask;
    begin
      mask = 7'h7f >> (3'h7 - code);
      if (code == `TPWM_DIV_EXT)
        presc_tick = ext_rise;
      else
        presc_tick = ((cnt | ~mask) == 7'h7f);
    end
  endfunction

  // ============================================================
  // Wishbone access
  reg         ack_r;
  reg  [31:0] dat_r;
  reg  [31:0] dat_nxt;
  wire        req     = I_WB_CYC & I_WB_STB & ~ack_r;
  wire        acc_ok  = ~I_WAIT_MODE;                      // [R19]
  wire        wr      = req & I_WB_WE & acc_ok;
  wire        rd      = req & ~I_WB_WE & acc_ok;
  wire        clr_ok  = ~I_BREAK | I_BREAK_CLEAR_EN;      // [R22]

  wire        st_hit  = (I_WB_ADR == `TPWM_ADR_STATUS);
  wire        per_hit = (I_WB_ADR == `TPWM_ADR_PERIOD);

  assign O_WB_ACK = ack_r;
  assign O_WB_DAT = dat_r;

  // ============================================================
  // External count pin: three flops, level accepted on agreement
  reg  [2:0]  ext_sync_r;
  reg         ext_lvl_r;
  wire        ext_rise = (ext_sync_r[1] == ext_sync_r[2]) & ext_sync_r[2] & ~ext_lvl_r;

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_sync_r <= 3'h0;
      ext_lvl_r  <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], I_EXT_CLK};
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_lvl_r <= ext_sync_r[2];
    end
  end

  // ============================================================
  // Timer status, prescaler and counter
  reg         ovf_flag_r;
  reg         ovf_ie_r;
  reg         halt_r;
  reg  [2:0]  div_r;
  reg         ovf_arm_r;
  reg  [15:0] period_r;
  reg  [6:0]  presc_r;
  reg  [15:0] cnt_r;
  localparam [7:0] rst_status = `TPWM_RST_STATUS;

  wire        run     = ~halt_r & ~I_STOP_MODE & ~I_BREAK; // [R20] [R21]
  wire        tick    = run & presc_tick(div_r, presc_r, ext_rise); // [R24]
  wire        ovf_evt = tick & (cnt_r == period_r);       // [R17]
  wire [15:0] cnt_nxt = ovf_evt ? 16'h0000 : cnt_r + 16'h0001; // [R27]
  wire        st_wr   = wr & st_hit & I_WB_SEL[0];
  wire        crst    = st_wr & I_WB_DAT[`TPWM_ST_CRST];
  wire        ovf_clr = st_wr & ~I_WB_DAT[`TPWM_ST_OVF] & ovf_arm_r & clr_ok;

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ovf_flag_r <= 1'b0;
      ovf_ie_r   <= 1'b0;
      halt_r     <= rst_status[`TPWM_ST_HALT];            // [R25]
      div_r      <= 3'h0;
      ovf_arm_r  <= 1'b0;
      period_r   <= `TPWM_RST_PERIOD;
      presc_r    <= 7'h00;
      cnt_r      <= 16'h0000;
    end else begin
      // Set wins over a clear in the same cycle
      ovf_flag_r <= ovf_evt | (ovf_flag_r & ~ovf_clr);    // [R5] [R23]
      if (ovf_evt || (st_wr && clr_ok))
        ovf_arm_r <= 1'b0;                                // [R23]
      else if (rd && st_hit && ovf_flag_r && clr_ok)
        ovf_arm_r <= 1'b1;
      if (st_wr) begin
        ovf_ie_r <= I_WB_DAT[`TPWM_ST_OVF_IE];
        halt_r   <= I_WB_DAT[`TPWM_ST_HALT];
        div_r    <= I_WB_DAT[`TPWM_ST_DIV_HI:`TPWM_ST_DIV_LO];
      end
      if (wr && per_hit && I_WB_SEL[0])
        period_r[7:0] <= I_WB_DAT[7:0];                   // [R3]
      if (wr && per_hit && I_WB_SEL[1])
        period_r[15:8] <= I_WB_DAT[15:8];
      // Counter reset touches only counter and prescaler
      if (crst) begin
        presc_r <= 7'h00;                                 // [R26]
        cnt_r   <= 16'h0000;
      end else begin
        if (run)
          presc_r <= presc_r + 7'h01;
        if (tick)
          cnt_r <= cnt_nxt;                               // [R27]
      end
    end
  end

  // ============================================================
  // Channels
  wire [8*NUM_CH-1:0]  ctl_flat;
  wire [16*NUM_CH-1:0] cmp_flat;
  wire [NUM_CH-1:0]    cmp_wr;
  wire [NUM_CH-1:0]    flag_w;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
      reg  [7:0]  ctl_r;
      reg  [15:0] cmp_r;
      reg         flag_r;
      reg         arm_r;
      reg         out_r;
      reg         out_nxt;
      wire [15:0] act_cmp;
      wire        linked;
      wire        freed;
      wire        ctl_hit = (I_WB_ADR == ch_adr(i));
      wire        cmp_hit = (I_WB_ADR == (ch_adr(i) | `TPWM_ADR_CH_CMP));
      wire        ctl_wr  = wr & ctl_hit & I_WB_SEL[0];
      wire [1:0]  act     = ctl_r[`TPWM_CH_ACT_HI:`TPWM_CH_ACT_LO];

      if ((i % 2) == 0) begin : g_even
        reg  sel_r;
        reg  last_r;
        wire last_nxt = cmp_wr[i+1] ? 1'b1 : (cmp_wr[i] ? 1'b0 : last_r);
        assign linked = ctl_r[`TPWM_CH_BUF];               // [R8] [R13]
        assign freed  = 1'b0;
        // Active member follows the last written one from each overflow
        assign act_cmp = sel_r ? cmp_flat[16*(i+1) +: 16] : cmp_r; // [R9]
        always @(posedge I_CLOCK or negedge I_RST_N) begin
          if (!I_RST_N) begin
            sel_r  <= 1'b0;
            last_r <= 1'b0;
          end else if (!linked) begin
            sel_r  <= 1'b0;                               // [R8]
            last_r <= 1'b0;
          end else begin
            last_r <= last_nxt;
            if (ovf_evt)
              sel_r <= last_nxt;                          // [R9]
          end
        end
      end else begin : g_odd
        assign linked  = 1'b0;
        assign freed   = ctl_flat[8*(i-1) + `TPWM_CH_BUF]; // [R10]
        assign act_cmp = cmp_r;
      end

      // Unbuffered compare writes take effect at once; misses are possible
      wire mode_on = linked | ctl_r[`TPWM_CH_UNBUF];      // [R13]
      wire live    = mode_on & ~freed;                    // [R10]
      wire cmp_evt = live & tick & (cnt_nxt == act_cmp);  // [R2] [R6]
      wire clr     = ctl_wr & ~I_WB_DAT[`TPWM_CH_FLAG] & arm_r & clr_ok;

      assign cmp_wr[i] = wr & cmp_hit & (|I_WB_SEL[1:0]);
      assign ctl_flat[8*i +: 8]  = {flag_r, ctl_r[6:0]};
      assign cmp_flat[16*i +: 16] = cmp_r;
      assign flag_w[i] = flag_r & ctl_r[`TPWM_CH_IE] & ~freed; // [R18]
      assign O_CH_OE[i]  = live & (act != `TPWM_ACT_NONE);  // [R10]
      assign O_CH_OUT[i] = out_r;

      // Compare action is applied after the overflow toggle
      always @* begin
        out_nxt = out_r;
        if (ovf_evt && ctl_r[`TPWM_CH_TOV] && live)
          out_nxt = ~out_r;                               // [R1] [R15]
        if (cmp_evt) begin
          case (act)
            `TPWM_ACT_TOGGLE: out_nxt = ~out_nxt;         // [R7]
            `TPWM_ACT_CLEAR:  out_nxt = 1'b0;             // [R14]
            `TPWM_ACT_SET:    out_nxt = 1'b1;             // [R14]
            default:          out_nxt = out_nxt;
          endcase
        end
        if (live && ctl_r[`TPWM_CH_FULL])
          out_nxt = ~act[0];                              // [R16]
      end

      always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          ctl_r  <= `TPWM_RST_CTL;
          cmp_r  <= `TPWM_RST_CMP;
          flag_r <= 1'b0;
          arm_r  <= 1'b0;
          out_r  <= 1'b0;
        end else begin
          out_r  <= out_nxt;
          flag_r <= cmp_evt | (flag_r & ~clr);            // [R4] [R18] [R22]
          if (cmp_evt || (ctl_wr && clr_ok))
            arm_r <= 1'b0;
          else if (rd && ctl_hit && flag_r && clr_ok)
            arm_r <= 1'b1;
          if (ctl_wr)
            ctl_r[6:0] <= I_WB_DAT[6:0];
          if (wr && cmp_hit && I_WB_SEL[0])
            cmp_r[7:0] <= I_WB_DAT[7:0];                  // [R3]
          if (wr && cmp_hit && I_WB_SEL[1])
            cmp_r[15:8] <= I_WB_DAT[15:8];
        end
      end
    end
  endgenerate

  // ============================================================
  // Read mux and acknowledge
  integer k;
  always @* begin
    dat_nxt = 32'h0000_0000;
    if (acc_ok) begin
      if (st_hit)
        dat_nxt[7:0] = {ovf_flag_r, ovf_ie_r, halt_r, 2'b00, div_r}; // [R26]
      else if (I_WB_ADR == `TPWM_ADR_COUNT)
        dat_nxt[15:0] = cnt_r;
      else if (per_hit)
        dat_nxt[15:0] = period_r;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        if (I_WB_ADR == ch_adr(k))
          dat_nxt[7:0] = ctl_flat[8*k +: 8];
        if (I_WB_ADR == (ch_adr(k) | `TPWM_ADR_CH_CMP))
          dat_nxt[15:0] = cmp_flat[16*k +: 16];
      end
    end
  end

  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req && !I_WB_WE)
        dat_r <= dat_nxt;
    end
  end

  // ============================================================
  // Requests: any enabled request also wakes the system
  assign O_OVF_IRQ = ovf_flag_r & ovf_ie_r;               // [R17]
  assign O_CH_IRQ  = flag_w;                              // [R18]
  assign O_WAKE    = O_OVF_IRQ | (|flag_w);               // [R19]

endmodule // timer_pwm_channels

// ==== inc/timer_pwm_map.vh ====
// Register map, field positions and reset values of the six-channel PWM timer.
// Assumes a 32-bit word-aligned Wishbone slave; fields sit in the low bits.
`ifndef TIMER_PWM_MAP_VH
`define TIMER_PWM_MAP_VH

// ============================================================
// Offsets (byte addresses)
`define TPWM_ADR_STATUS     8'h00
`define TPWM_ADR_COUNT      8'h04
`define TPWM_ADR_PERIOD     8'h08
`define TPWM_ADR_CH_BASE    8'h10
`define TPWM_ADR_CH_CMP     8'h04

// ============================================================
// Timer status/control fields
`define TPWM_ST_OVF         7
`define TPWM_ST_OVF_IE      6
`define TPWM_ST_HALT        5
`define TPWM_ST_CRST        4
`define TPWM_ST_DIV_HI      2
`define TPWM_ST_DIV_LO      0
`define TPWM_DIV_EXT        3'h7

// ============================================================
// Channel status/control fields
`define TPWM_CH_FLAG        7
`define TPWM_CH_IE          6
`define TPWM_CH_BUF         5
`define TPWM_CH_UNBUF       4
`define TPWM_CH_ACT_HI      3
`define TPWM_CH_ACT_LO      2
`define TPWM_CH_TOV         1
`define TPWM_CH_FULL        0
`define TPWM_ACT_NONE       2'h0
`define TPWM_ACT_TOGGLE     2'h1
`define TPWM_ACT_CLEAR      2'h2
`define TPWM_ACT_SET        2'h3

// ============================================================
// Reset values
`define TPWM_RST_STATUS     8'h20
`define TPWM_RST_PERIOD     16'hffff
`define TPWM_RST_CTL        8'h00
`define TPWM_RST_CMP        16'h0000

`endif

// ==== bench/timer_pwm_checker.sv ====
// Port-level assertions for the six-channel PWM timer.
// Assumes one clock and an async active-low reset; bound below.
`timescale 1ns/1ps
module timer_pwm_checker #(
  parameter NUM_CH = 6
) (
  input wire              I_CLOCK,
  input wire              I_RST_N,
  input wire              I_WB_CYC,
  input wire              I_WB_STB,
  input wire              I_WB_WE,
  input wire [7:0]        I_WB_ADR,
  input wire              I_WAIT_MODE,
  input wire              I_STOP_MODE,
  input wire              I_BREAK,
  input wire              I_BREAK_CLEAR_EN,
  input wire [31:0]       O_WB_DAT,
  input wire              O_WB_ACK,
  input wire              O_OVF_IRQ,
  input wire [NUM_CH-1:0] O_CH_IRQ,
  input wire              O_WAKE,
  input wire [NUM_CH-1:0] O_CH_OUT
);
  // ============================================================
  // Properties
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  ack_single_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack wider than one cycle");
  ack_take_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack late");
  wake_or_a: assert property (O_WAKE == (O_OVF_IRQ || |O_CH_IRQ))
    else $error("wake differs from requests");
  wait_read_a: assert property (O_WB_ACK && $past(I_WAIT_MODE && !I_WB_WE) |-> O_WB_DAT == 0)
    else $error("read in wait mode not zero");
  crst_read_a: assert property (O_WB_ACK && $past(!I_WB_WE && I_WB_ADR == 8'h00) |-> !O_WB_DAT[4])
    else $error("counter reset bit read as one");
  halt_pins_a: assert property ($past((I_BREAK || I_STOP_MODE)
    && !(I_WB_STB && I_WB_WE)) |-> $stable(O_CH_OUT))
    else $error("pins moved while halted");
  break_flags_a: assert property ($past(I_BREAK && !I_BREAK_CLEAR_EN
    && !(I_WB_STB && I_WB_WE)) |-> $stable(O_OVF_IRQ) && $stable(O_CH_IRQ))
    else $error("request changed in break");
  stop_flags_a: assert property ($past(I_STOP_MODE) |-> !$rose(O_OVF_IRQ))
    else $error("overflow while stopped");
endmodule // timer_pwm_checker

bind timer_pwm_channels timer_pwm_checker #(.NUM_CH(NUM_CH)) chk_i (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WAIT_MODE(I_WAIT_MODE),
  .I_STOP_MODE(I_STOP_MODE), .I_BREAK(I_BREAK), .I_BREAK_CLEAR_EN(I_BREAK_CLEAR_EN),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_OVF_IRQ(O_OVF_IRQ),
  .O_CH_IRQ(O_CH_IRQ), .O_WAKE(O_WAKE), .O_CH_OUT(O_CH_OUT));

// ==== bench/pwm_load_model.sv ====
// Load on channel 0 pin: measures high time and period between rises.
// Assumes a pull-down on the line, so an undriven pin reads low.
`timescale 1ns/1ps
module pwm_load_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        pin,
  input  wire        oe,
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  // ============================================================
  // Measurement
  logic        line_d;
  logic [15:0] hc, pc;
  wire         line = oe ? pin : 1'b0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {line_d, hc, pc, high_len, period_len} <= '0;
    end else begin
      line_d <= line;
      if (line && !line_d) begin
        high_len <= hc;
        period_len <= pc;
        hc <= 16'h1;
        pc <= 16'h1;
      end else begin
        pc <= pc + 16'h1;
        hc <= hc + {15'h0, line};
      end
    end
  end
endmodule // pwm_load_model

// ==== bench/tb.sv ====
// Self-checking bench for the PWM timer over classic Wishbone.
// Assumes the load model on channel 0 and the bound checker.
`timescale 1ns/1ps
module tb;
  // ============================================================
  // Signals
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, wait_m = 0;
  logic        stop_m = 0, brk = 0, bce = 0, ext = 0;
  logic [3:0]  wsel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd_v, v, seed = 32'hd546eaea;
  logic [15:0] p, w;
  logic [15:0] wv [3] = '{16'h4, 16'h9, 16'h2};
  wire  [31:0] rdat;
  wire  [5:0]  ch_irq, ch_out, ch_oe;
  wire         ack, ovf_irq, wake;
  wire  [15:0] hi_len, per_len;
  integer      err_count = 0, checked = 0;
  always #2.5 clk = ~clk;
  always #40 ext = ~ext;
  timer_pwm_channels uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(wsel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_WAIT_MODE(wait_m), .I_STOP_MODE(stop_m), .I_BREAK(brk),
    .I_BREAK_CLEAR_EN(bce), .I_EXT_CLK(ext), .O_OVF_IRQ(ovf_irq), .O_CH_IRQ(ch_irq),
    .O_WAKE(wake), .O_CH_OUT(ch_out), .O_CH_OE(ch_oe));
  pwm_load_model load_i (.clk(clk), .rst_n(rst_n), .pin(ch_out[0]), .oe(ch_oe[0]),
    .high_len(hi_len), .period_len(per_len));
  // ============================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic int sh(input logic [2:0] c);
    sh = (c == 3'h7) ? 4 : c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    wsel <= 4'h3;
    // Waits for ack however long; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd_v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // Halt and clear, period, width, mode, then start
  task automatic pwm(input logic [2:0] c, input logic [15:0] pp, input logic [15:0] ww,
                     input logic [7:0] ctl);
    bus(1'b1, 8'h00, 32'h30);
    bus(1'b1, 8'h08, {16'h0, pp});
    bus(1'b1, 8'h14, {16'h0, ww});
    bus(1'b1, 8'h10, {24'h0, ctl});
    bus(1'b1, 8'h00, {29'h0, c});
    repeat (3 * ((pp + 1) << sh(c))) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ============================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h20);
    rdc(8'h08, 32'hffff);
    rdc(8'hfc, 32'h0);
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      p = {12'h0, seed[3:0] | 4'h3};
      w = 16'h1 + seed[15:8] % p;
      pwm(c[2:0], p, w, 8'h5a);
      chk(hi_len, w << sh(c[2:0]));
      chk(per_len, (p + 1) << sh(c[2:0]));
      chk(ch_irq[0], 1'b1);
      chk(wake, 1'b1);
    end
    pwm(3'h0, 16'h00ff, 16'h0080, 8'h1a);
    chk(hi_len, 32'd128);
    chk(per_len, 32'd256);
    pwm(3'h0, 16'h7, 16'h3, 8'h1e);
    chk(hi_len, 32'h5);
    pwm(3'h0, 16'h7, 16'h3, 8'h18);
    chk(ch_out[0], 1'b0);
    pwm(3'h0, 16'h7, 16'h3, 8'h19);
    chk(ch_out[0], 1'b1);
    $display("pwm modes done");
    bus(1'b1, 8'h00, 32'h40);
    repeat (40) @(posedge clk);
    chk(ovf_irq, 1'b1);
    bus(1'b1, 8'h00, 32'he0);
    rdc(8'h00, 32'he0);
    brk <= 1'b1;
    bus(1'b1, 8'h00, 32'h60);
    rdc(8'h00, 32'he0);
    brk <= 1'b0;
    bus(1'b1, 8'h00, 32'h60);
    rdc(8'h00, 32'h60);
    chk(ovf_irq, 1'b0);
    wait_m <= 1'b1;
    bus(1'b1, 8'h08, 32'h5);
    rdc(8'h00, 32'h0);
    wait_m <= 1'b0;
    rdc(8'h08, 32'h7);
    $display("flags done");
    bus(1'b1, 8'h00, 32'h0);
    for (int m = 0; m < 2; m++) begin
      {brk, stop_m} <= m ? 2'b10 : 2'b01;
      bus(1'b0, 8'h04, 32'h0);
      v = rd_v;
      repeat (30) @(posedge clk);
      rdc(8'h04, v);
      {brk, stop_m} <= 2'b00;
      @(posedge clk);
    end
    bus(1'b1, 8'h00, 32'h30);
    rdc(8'h04, 32'h0);
    rdc(8'h00, 32'ha0);
    bus(1'b1, 8'h08, 32'hf);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, i[0] ? 8'h1c : 8'h14, {16'h0, wv[i]});
      if (i == 0) bus(1'b1, 8'h10, 32'h2a);
      if (i == 0) bus(1'b1, 8'h00, 32'h0);
      repeat (48) @(posedge clk);
      chk(hi_len, wv[i]);
      chk(ch_oe[1:0], 2'b01);
    end
    $display("halt and pair done");
    conclude;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude;
  end
endmodule // tb
